/* hw/indicator_chain.v */
// indicator output chain: selection, stretch, mix, blink, polarity, pins
// assumes status inputs on aclk and an AXI4-Lite master on the same clock
//
// What this block does
// R1: the two lower pins stay released for strap sampling until config ends.
// R2: select bits 11:8, 7:4 and 3:0 steer the top, middle and bottom pins.
// R3: bottom selector bits 3:2 at 11 join the lower pins; middle sel ignored.
// R4: each pin has a 2-bit polarity: low bit active level, high bit hi-z off.
// R5: codes 00, 01, 10, 11 give low/high, high/low, low/z and high/z.
// R6: only transmit, receive and combined activity are stretched.
// R7: the 3-bit stretch code picks none or 21 ms up to 1.3 s.
// R8: the 3-bit blink code picks 42 to 670 ms; codes above 100 are reserved.
// R9: stretching comes before blinking so a blink lasts the stretched pulse.
// R10: blinking follows mixing and polarity is the very last stage.
// R11: selector codes 1000 to 1011 force off, on, hi-z or blinking.
// R12: in dual modes at 10 Mbps each lower pin is on for a mix fraction in 1/8 steps.
// R13: all millisecond timing comes from one free-running prescaler.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "indicator_defines.vh"

module indicator_chain #(
  parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // core status
  input  wire        config_done,
  input  wire        link_up,
  input  wire [1:0]  link_speed,
  input  wire        full_duplex,
  input  wire        collision,
  input  wire        tx_activity,
  input  wire        rx_activity,
  input  wire        copper_link,
  input  wire        fiber_link,
  // indicator pins, oe_n low while driving
  output reg  [2:0]  indicator_pins_out,
  output reg  [2:0]  indicator_pins_oe_n
);

  reg  [15:0] indicator_select;
  reg  [15:0] indicator_polarity_mix;
  reg  [15:0] indicator_stretch_blink_timing;

  // ---------------- axi4-lite slave ----------------
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        do_write;
  wire        wr_hit;
  reg  [15:0] rd_val;
  reg         rd_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit        = aw_addr == `OFF_SELECT || aw_addr == `OFF_POLMIX ||
                         aw_addr == `OFF_TIMING;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      indicator_select               <= `RST_SELECT;
      indicator_polarity_mix         <= `RST_POLMIX;
      indicator_stretch_blink_timing <= `RST_TIMING;
    end else if (do_write) begin
      case (aw_addr)
        `OFF_SELECT: begin
          if (w_strb[0]) indicator_select[7:0]  <= w_data[7:0];
          if (w_strb[1]) indicator_select[15:8] <= w_data[15:8];
        end
        `OFF_POLMIX: begin
          if (w_strb[0]) indicator_polarity_mix[7:0]  <= w_data[7:0];
          if (w_strb[1]) indicator_polarity_mix[15:8] <= w_data[15:8];
        end
        `OFF_TIMING: begin
          if (w_strb[0]) indicator_stretch_blink_timing[7:0]  <= w_data[7:0];
          if (w_strb[1]) indicator_stretch_blink_timing[15:8] <= w_data[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFF_SELECT: rd_val = indicator_select;
      `OFF_POLMIX: rd_val = indicator_polarity_mix;
      `OFF_TIMING: rd_val = indicator_stretch_blink_timing;
      `OFF_STATUS: rd_val = {9'h000, config_done, indicator_pins_oe_n,
                             indicator_pins_out};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- common time base ----------------
  reg  [17:0] prescale;
  reg         ms_tick;
  reg  [2:0]  pwm;
  reg  [11:0] blink_cnt;
  reg         blink_phase;
  wire [2:0]  stretch_code = indicator_stretch_blink_timing[`STRETCH_HI:`STRETCH_LO];
  wire [2:0]  blink_code   = indicator_stretch_blink_timing[`BLINK_HI:`BLINK_LO];
  reg  [11:0] blink_ms;
  reg  [11:0] stretch_ms;

  // a table keeps the set durations exact, not rounded to powers of two
  always @* begin
    case (blink_code)
      3'h0:    blink_ms = `BLINK_MS_0; // R8
      3'h1:    blink_ms = `BLINK_MS_1; // R8
      3'h2:    blink_ms = `BLINK_MS_2; // R8
      3'h3:    blink_ms = `BLINK_MS_3; // R8
      default: blink_ms = `BLINK_MS_4; // R8
    endcase
    case (stretch_code)
      3'h1:    stretch_ms = `STRETCH_MS_1; // R7
      3'h2:    stretch_ms = `STRETCH_MS_2; // R7
      3'h3:    stretch_ms = `STRETCH_MS_3; // R7
      3'h4:    stretch_ms = `STRETCH_MS_4; // R7
      3'h5:    stretch_ms = `STRETCH_MS_5; // R7
      3'h6:    stretch_ms = `STRETCH_MS_6; // R7
      3'h7:    stretch_ms = `STRETCH_MS_7; // R7
      default: stretch_ms = 12'h000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      prescale    <= 18'h00000;
      ms_tick     <= 1'b0;
      blink_cnt   <= 12'h000;
      blink_phase <= 1'b0;
      pwm         <= 3'h0;
    end else begin
      pwm <= pwm + 3'h1;
      // one shared prescaler keeps all pins in step
      if (prescale == MS_CYCLES[17:0] - 18'h00001) begin // R13
        prescale <= 18'h00000;
        ms_tick  <= 1'b1;
      end else begin
        prescale <= prescale + 18'h00001;
        ms_tick  <= 1'b0;
      end
      if (ms_tick) begin
        if (blink_cnt >= blink_ms - 12'h001) begin // R8
          blink_cnt   <= 12'h000;
          blink_phase <= ~blink_phase;
        end else begin
          blink_cnt <= blink_cnt + 12'h001;
        end
      end
    end
  end

  // ---------------- stretchers: tx, rx, combined ----------------
  wire [2:0]  act_raw = {tx_activity | rx_activity, rx_activity, tx_activity};
  wire [2:0]  act_str;
  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : g_stretch
      reg [11:0] hold;
      always @(posedge aclk) begin
        if (!aresetn) begin
          hold <= 12'h000;
        end else if (act_raw[s] && stretch_code != 3'h0) begin
          hold <= stretch_ms; // R6
        end else if (ms_tick && hold != 12'h000) begin
          hold <= hold - 12'h001;
        end
      end
      assign act_str[s] = act_raw[s] | (hold != 12'h000); // R6
    end
  endgenerate

  wire tx_s  = act_str[0];
  wire rx_s  = act_str[1];
  wire act_s = act_str[2];
  wire s10   = link_up && link_speed == 2'h0;
  wire s100  = link_up && link_speed == 2'h1;
  wire s1000 = link_up && link_speed == 2'h2;
  wire dual  = indicator_select[3:2] == `DUAL_CODE; // R3

  // ---------------- per-pin chain ----------------
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pin
      wire [3:0] sel = indicator_select[4*p+3:4*p]; // R2
      wire [1:0] pol = indicator_polarity_mix[2*p+1:2*p]; // R4
      wire [3:0] mix;
      reg        on;
      reg        hiz;
      reg        dual_on;
      if (p == 0) begin : g_m0
        assign mix = indicator_polarity_mix[`MIX_BOT_HI:`MIX_BOT_LO];
      end else begin : g_m1
        assign mix = indicator_polarity_mix[`MIX_MID_HI:`MIX_MID_LO];
      end

      always @* begin
        hiz = 1'b0;
        case (sel)
          4'h0: on = (p == 1) ? rx_s : link_up;
          // blink runs for the whole stretched pulse
          4'h1: on = link_up & (act_s ? blink_phase : 1'b1); // R9
          4'h2: begin
            if (p == 2)
              on = full_duplex & (collision ? blink_phase : 1'b1);
            else if (p == 1)
              on = link_up & (rx_s ? blink_phase : 1'b1); // R9
            else
              on = link_up & blink_phase;
          end
          4'h3: on = act_s;
          4'h4: on = act_s & blink_phase; // R9
          4'h5: on = (p == 1) ? (s100 | fiber_link) : tx_s;
          4'h6: on = (p == 2) ? (s10 | s1000) :
                     (p == 1) ? (s100 | s1000) : copper_link;
          4'h7: on = (p == 2) ? s10 : (p == 1) ? s100 : s1000;
          `SEL_FORCE_OFF:   on = 1'b0; // R11
          `SEL_FORCE_ON:    on = 1'b1; // R11
          `SEL_FORCE_HIZ: begin
            on  = 1'b0;
            hiz = 1'b1; // R11
          end
          `SEL_FORCE_BLINK: on = blink_phase; // R11
          default:          on = 1'b0;
        endcase
        // 10 Mbps shows as the mixed third colour on both lower pins
        dual_on = link_up & (((p == 0) ? s1000 : s100) |
                  (s10 & ({1'b0, pwm} < mix))); // R12
        if (indicator_select[0])
          dual_on = dual_on & (act_s ? blink_phase : 1'b1); // R9
      end

      // mixing then polarity, registered straight onto the pin
      wire use_dual = dual && p < 2; // R3
      wire active   = use_dual ? dual_on : on; // R10
      wire off_hiz  = use_dual ? pol[1] & ~dual_on :
                      hiz | (pol[1] & ~on); // R5
      always @(posedge aclk) begin
        if (!aresetn) begin
          indicator_pins_out[p]  <= 1'b0;
          indicator_pins_oe_n[p] <= 1'b1;
        end else if (p < 2 && !config_done) begin
          // pins belong to strap sampling until configuration ends
          indicator_pins_out[p]  <= 1'b0; // R1
          indicator_pins_oe_n[p] <= 1'b1; // R1
        end else begin
          indicator_pins_out[p]  <= active ? pol[0] : ~pol[0]; // R5
          indicator_pins_oe_n[p] <= off_hiz & ~(active & ~use_dual & hiz)
                                    | (hiz & ~use_dual); // R10
        end
      end
    end
  endgenerate

endmodule // indicator_chain
`default_nettype wire

/* shared/indicator_defines.vh */
// constants for the indicator output chain: offsets, fields, resets, timing
// assumes a 32-bit AXI4-Lite register port and a 200 MHz core clock
`ifndef INDICATOR_DEFINES_VH
`define INDICATOR_DEFINES_VH

// register byte offsets
`define OFF_SELECT      8'h00
`define OFF_POLMIX      8'h04
`define OFF_TIMING      8'h08
`define OFF_STATUS      8'h0c

// reset values
`define RST_SELECT      16'h0000
`define RST_POLMIX      16'h0000
`define RST_TIMING      16'h0000

// selector fields in the select register
`define SEL_TOP_HI      11
`define SEL_TOP_LO      8
`define SEL_MID_HI      7
`define SEL_MID_LO      4
`define SEL_BOT_HI      3
`define SEL_BOT_LO      0

// polarity and mix fields
`define POL_TOP_LO      4
`define POL_MID_LO      2
`define POL_BOT_LO      0
`define MIX_MID_HI      15
`define MIX_MID_LO      12
`define MIX_BOT_HI      11
`define MIX_BOT_LO      8

// timing fields
`define STRETCH_HI      14
`define STRETCH_LO      12
`define BLINK_HI        10
`define BLINK_LO        8

// selector codes
`define SEL_FORCE_OFF   4'h8
`define SEL_FORCE_ON    4'h9
`define SEL_FORCE_HIZ   4'ha
`define SEL_FORCE_BLINK 4'hb
`define DUAL_CODE       2'h3

// time base
`define CLK_NS          5
`define MS_NS           1000000
`define STRETCH_MS_1    12'h015
`define STRETCH_MS_2    12'h02a
`define STRETCH_MS_3    12'h054
`define STRETCH_MS_4    12'h0aa
`define STRETCH_MS_5    12'h154
`define STRETCH_MS_6    12'h29e
`define STRETCH_MS_7    12'h514
`define BLINK_MS_0      12'h02a
`define BLINK_MS_1      12'h054
`define BLINK_MS_2      12'h0aa
`define BLINK_MS_3      12'h154
`define BLINK_MS_4      12'h29e

// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* tb/indicator_chain_chk.sv */
// checker for the indicator chain register port and pin release
// assumes a bind into indicator_chain, one clock aclk, reset aresetn
`timescale 1ns/1ps
`default_nettype none

module indicator_chain_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register port
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins
  input wire logic        config_done,
  input wire logic [2:0]  indicator_pins_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pins_released: assert property (
    !$past(config_done) |-> indicator_pins_oe_n[1:0] == 2'b11)
    else $error("lower pins driven before config");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule // indicator_chain_chk

bind indicator_chain indicator_chain_chk chk_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .config_done, .indicator_pins_oe_n
);

`default_nettype wire

/* tb/indicator_lamps.sv */
// lamp model on the three indicator pins
// assumes no pull resistors, so a released pin floats
`timescale 1ns/1ps
`default_nettype none

module indicator_lamps (
  // clock
  input  wire logic       aclk,
  // pin drive
  input  wire logic [2:0] pins_out,
  input  wire logic [2:0] pins_oe_n,
  // level seen on the board
  output wire logic [2:0] pad
);
  logic [2:0] last = 3'h0;

  // a floating pin toggles so a stale level never reads as driven
  assign pad = (pins_out & ~pins_oe_n) | (~last & pins_oe_n);
  always @(posedge aclk) begin
    // an unknown level before reset counts as low so the toggle can start
    for (int i = 0; i < 3; i++) begin
      last[i] <= pad[i] === 1'b1;
    end
  end
endmodule // indicator_lamps

`default_nettype wire

/* tb/test_indicator_chain.sv */
// self-checking bench for the indicator chain
// assumes the lamp model on the pins and a register master on aclk
`timescale 1ns/1ps
`default_nettype none
`include "indicator_defines.vh"

module test_indicator_chain;
  // short millisecond keeps blink and stretch runs brief
  localparam MS = 4;
  logic        aclk = 0, aresetn = 0, config_done = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, link_up = 0;
  logic        full_duplex = 0, collision = 0, copper_link = 0;
  logic        fiber_link = 0, tx_activity = 0, rx_activity = 0;
  logic [1:0]  link_speed = 0, rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [2:0]  indicator_pins_out, indicator_pins_oe_n, pad;
  int          fails = 0, compares = 0;

  indicator_chain #(.MS_CYCLES(MS)) indicator_chain_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .config_done, .link_up, .link_speed, .full_duplex,
    .collision, .tx_activity, .rx_activity, .copper_link, .fiber_link,
    .indicator_pins_out, .indicator_pins_oe_n);
  indicator_lamps indicator_lamps_i (.aclk, .pins_out(indicator_pins_out),
    .pins_oe_n(indicator_pins_oe_n), .pad);

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end while (aw || w);
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ar;
    ar = 1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      ar = ar && !s_axi_arready;
      s_axi_arvalid <= ar;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // bottom pin: cycles from one change to the next
  task automatic gap(output int n);
    logic v;
    v = indicator_pins_out[0];
    do @(posedge aclk); while (indicator_pins_out[0] === v);
    v = indicator_pins_out[0];
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (indicator_pins_out[0] === v);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 12; i += 4) begin
      rdr(i[7:0]);
      chk("reset value", rd, 32'h0);
    end
    rdr(8'h10);
    chk("unmapped read", {rd[29:0], rs}, {30'h0, `RESP_SLVERR});
    wr(8'h10, 16'hffff, 4'hf);
    chk("unmapped write", rs, `RESP_SLVERR);
    wr(`OFF_POLMIX, 16'h8765, 4'h2);
    rdr(`OFF_POLMIX);
    chk("byte strobe", rd, 32'h8700);
  endtask

  task automatic t_release;
    wr(`OFF_POLMIX, 16'h0000, 4'h3);
    wr(`OFF_SELECT, 16'h0099, 4'h3);
    tick(3);
    chk("held oe", indicator_pins_oe_n, 3'b011);
    chk("held pad", pad[2], 1'b1);
    config_done <= 1'b1;
    tick(3);
    chk("free oe", indicator_pins_oe_n, 3'b000);
    chk("free pad", pad, 3'b100);
  endtask

  task automatic t_polarity;
    wr(`OFF_SELECT, 16'h0989, 4'h3);
    for (int c = 0; c < 4; c++) begin
      wr(`OFF_POLMIX, 16'(c * 21), 4'h3);
      tick(3);
      chk("pol oe", indicator_pins_oe_n, {1'b0, c[1], 1'b0});
      chk("pol pad", pad | {1'b0, c[1], 1'b0},
          {c[0], ~c[0] | c[1], c[0]});
    end
    wr(`OFF_SELECT, 16'h0a89, 4'h3);
    tick(3);
    chk("forced hiz", indicator_pins_oe_n, 3'b110);
  endtask

  task automatic t_blink;
    int n, r;
    wr(`OFF_POLMIX, 16'h0001, 4'h3);
    wr(`OFF_SELECT, 16'h000b, 4'h3);
    for (int c = 0; c < 6; c++) begin
      wr(`OFF_TIMING, 16'(c << 8), 4'h3);
      gap(n);
      r = c == 0 ? 42 : c == 1 ? 84 : c == 2 ? 170 : c == 3 ? 340 : 670;
      chk("blink gap", n, r * MS);
    end
  endtask

  task automatic t_stretch;
    int n, t;
    wr(`OFF_SELECT, 16'h0003, 4'h3);
    for (int c = 0; c < 3; c++) begin
      t = c == 0 ? 0 : 21 << (c - 1);
      wr(`OFF_TIMING, 16'(c << 12), 4'h3);
      tx_activity <= c != 1;
      rx_activity <= c == 1;
      @(posedge aclk);
      tx_activity <= 1'b0;
      rx_activity <= 1'b0;
      gap(n);
      chk("stretch", n >= (t - 1) * MS + 1 && n <= t * MS + 2, 1);
    end
    wr(`OFF_SELECT, 16'h0000, 4'h3);
    wr(`OFF_TIMING, 16'h7000, 4'h3);
    link_up <= 1'b1;
    link_speed <= 2'h2;
    tick(3);
    chk("link on", indicator_pins_out[0], 1'b1);
    link_up <= 1'b0;
    tick(3);
    chk("link off", indicator_pins_out[0], 1'b0);
  endtask

  // 84 ms stretch blinked at 42 ms: about half the stretched pulse is lit
  task automatic t_stretch_blink;
    int nb;
    nb = 0;
    wr(`OFF_SELECT, 16'h0004, 4'h3);
    wr(`OFF_TIMING, 16'h3000, 4'h3);
    tx_activity <= 1'b1;
    @(posedge aclk);
    tx_activity <= 1'b0;
    repeat (400) begin
      @(posedge aclk);
      nb += indicator_pins_out[0];
    end
    chk("blink stretch", nb >= 160 && nb <= 176, 1);
    chk("stretch end", indicator_pins_out[0], 1'b0);
  endtask

  task automatic mode(input logic [15:0] s, input logic [1:0] v,
                      input logic [2:0] e);
    link_speed <= v;
    wr(`OFF_SELECT, s, 4'h3);
    tick(3);
    chk("mode pins", indicator_pins_out, e);
  endtask

  task automatic t_modes;
    wr(`OFF_POLMIX, 16'h0015, 4'h3);
    link_up <= 1'b1;
    full_duplex <= 1'b1;
    copper_link <= 1'b1;
    mode(16'h0777, 2'h2, 3'b001);
    mode(16'h0777, 2'h0, 3'b100);
    mode(16'h0666, 2'h1, 3'b011);
    mode(16'h0555, 2'h1, 3'b010);
    mode(16'h0220, 2'h2, 3'b111);
  endtask

  task automatic t_dual;
    int nb, nm;
    nb = 0;
    nm = 0;
    link_up <= 1'b1;
    link_speed <= 2'h0;
    wr(`OFF_POLMIX, 16'h2615, 4'h3);
    wr(`OFF_SELECT, 16'h009c, 4'h3);
    tick(3);
    repeat (64) begin
      @(posedge aclk);
      nb += indicator_pins_out[0];
      nm += indicator_pins_out[1];
    end
    chk("mix bottom", nb, 48);
    chk("mix middle", nm, 16);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_release;
    t_polarity;
    t_blink;
    t_stretch;
    t_stretch_blink;
    t_modes;
    t_dual;
    end_sim;
  end

  // about 17k cycles expected, mostly the slow blink codes
  initial begin
    #300000;
    fails++;
    end_sim;
  end
endmodule // test_indicator_chain

`default_nettype wire
